// [hw/irpu_consts.vh]
`ifndef IRPU_CONSTS_VH
`define IRPU_CONSTS_VH

// register byte offsets
`define IRPU_OFF_CTRL 8'h00
`define IRPU_OFF_CFG 8'h04
`define IRPU_OFF_STATE 8'h08
`define IRPU_OFF_TYPE 8'h0C
`define IRPU_OFF_IST 8'h10
`define IRPU_OFF_IMSK 8'h14

// control register fields
`define IRPU_CTRL_CASC0 0
`define IRPU_CTRL_CASC1 1
`define IRPU_CTRL_SLAVE 2
`define IRPU_CTRL_W 3
`define IRPU_CTRL_RST 3'h0

// configuration register fields: mask bits and level-trigger bits
`define IRPU_CFG_MASK_LO 0
`define IRPU_CFG_MASK_HI 4
`define IRPU_CFG_TRIG_LO 8
`define IRPU_CFG_TRIG_HI 12
`define IRPU_MASK_RST 5'h1F
`define IRPU_TRIG_RST 5'h00

// state register fields
`define IRPU_ST_STATE_LO 0
`define IRPU_ST_STATE_HI 1
`define IRPU_ST_ACT_LO 8
`define IRPU_ST_ACT_HI 12
`define IRPU_ST_LVL_LO 16
`define IRPU_ST_LVL_HI 20

// interrupt status bits: 4..0 request edges, then type captures
`define IRPU_IST_SLV_TYPE 5
`define IRPU_IST_CASC_TYPE 6
`define IRPU_IST_W 7

`define IRPU_RESP_OKAY 2'h0
`define IRPU_RESP_SLVERR 2'h2

`define IRPU_NREQ 5
`define IRPU_TYPE_W 8

`endif

// [hw/irpu_sync.v]
`timescale 1ns/1ps
module irpu_sync #(
  parameter W = 1
) (
  clk,
  ce,
  reset,
  async_in,
  sync_out
);
  input wire clk;
  input wire ce;
  input wire reset;
  input wire [W-1:0] async_in;
  output wire [W-1:0] sync_out;

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else if (ce) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

// [hw/irpu_req_chan.v]
`timescale 1ns/1ps
module irpu_req_chan (
  clk,
  ce,
  reset,
  level,
  trig_level,
  masked,
  clear,
  active,
  rise
);
  input wire clk;
  input wire ce;
  input wire reset;
  input wire level;
  input wire trig_level;
  input wire masked;
  input wire clear;
  output wire active;
  output wire rise;

  reg prev_reg;
  reg latch_reg;
  wire latch_next;

  assign rise = level & ~prev_reg;
  // an edge arriving with the clear is kept
  assign latch_next = rise ? 1'b1 : (clear ? 1'b0 : latch_reg);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      prev_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else if (ce) begin
      prev_reg <= level;
      latch_reg <= latch_next;
    end
  end

  // level mode follows the pin, so the requester must hold it until serviced
  assign active = ~masked & (trig_level ? level : latch_reg);
endmodule

// [hw/irpu_top.v]
// Functional notes
// - outside slave mode an unmasked request on a non-cascaded input presents the vector entry that belongs to its input
// - every request pin is synchronised before the interrupt logic sees it
// - each request input is edge or level triggered per its trigger bit
// - in slave mode the select strobe captures the type from the bus
// - cascade on request 0 turns pin 2 into type acknowledge 0 output
// - cascade on request 1 turns pin 3 into type acknowledge 1 output
// - type acknowledge 0 asserts while servicing request 0 in cascade
// - type acknowledge 1 asserts while servicing request 1 in cascade
// - in slave mode pin 3 drives a request toward the external master
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "irpu_consts.vh"
module irpu_top #(
  parameter [7:0] VEC_BASE = 8'h10,
  parameter ACK_CYC = 4
) (
  clk,
  ce,
  reset,
  mask_req_0,
  mask_req_1,
  mask_req_2_in,
  type_ack_0_out,
  type_ack_0_oe,
  mask_req_3_in,
  pin3_out,
  pin3_oe,
  mask_req_4,
  ad_in,
  exec_req,
  exec_type,
  exec_ack,
  irq,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready
);
  input wire clk;
  input wire ce;
  input wire reset;
  input wire mask_req_0;
  input wire mask_req_1;
  input wire mask_req_2_in;
  output wire type_ack_0_out;
  output wire type_ack_0_oe;
  input wire mask_req_3_in;
  output wire pin3_out;
  output wire pin3_oe;
  input wire mask_req_4;
  input wire [7:0] ad_in;
  output wire exec_req;
  output wire [7:0] exec_type;
  input wire exec_ack;
  output wire irq;
  input wire [7:0] s_axi_awaddr;
  input wire s_axi_awvalid;
  output wire s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output wire s_axi_wready;
  output wire [1:0] s_axi_bresp;
  output wire s_axi_bvalid;
  input wire s_axi_bready;
  input wire [7:0] s_axi_araddr;
  input wire s_axi_arvalid;
  output wire s_axi_arready;
  output wire [31:0] s_axi_rdata;
  output wire [1:0] s_axi_rresp;
  output wire s_axi_rvalid;
  input wire s_axi_rready;

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CASC = 2'h1;
  localparam [1:0] ST_SLV = 2'h2;
  localparam [1:0] ST_PRES = 2'h3;
  localparam NREQ = `IRPU_NREQ;
  localparam [7:0] ACK_LAST = ACK_CYC - 1;

  // configuration registers
  reg [`IRPU_CTRL_W-1:0] ctrl_reg;
  reg [NREQ-1:0] mask_reg;
  reg [NREQ-1:0] trig_reg;
  reg [`IRPU_IST_W-1:0] ist_reg;
  reg [`IRPU_IST_W-1:0] imsk_reg;
  reg irq_reg;

  // axi slave state
  reg aw_hold_reg;
  reg [7:0] awaddr_reg;
  reg w_hold_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;

  // service state
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] src_reg;
  reg [2:0] src_next;
  reg [7:0] cnt_reg;
  reg [7:0] type_reg;
  reg [7:0] type_next;
  reg exec_req_reg;
  reg ack0_reg;
  reg pin3_reg;
  reg ack0_oe_reg;
  reg pin3_oe_reg;
  reg sel_prev_reg;
  reg casc_cap;
  reg slv_cap;

  wire casc0 = ctrl_reg[`IRPU_CTRL_CASC0] & ~ctrl_reg[`IRPU_CTRL_SLAVE];
  wire casc1 = ctrl_reg[`IRPU_CTRL_CASC1] & ~ctrl_reg[`IRPU_CTRL_SLAVE];
  wire slave_en = ctrl_reg[`IRPU_CTRL_SLAVE];

  wire [NREQ-1:0] pin_sync;
  wire [7:0] ad_sync;
  wire [NREQ-1:0] req_lvl;
  wire [NREQ-1:0] req_act;
  wire [NREQ-1:0] req_rise;
  reg [NREQ-1:0] req_clr;

  irpu_sync #(.W(NREQ)) u_pin_sync (
    .clk(clk),
    .ce(ce),
    .reset(reset),
    .async_in({mask_req_4, mask_req_3_in, mask_req_2_in, mask_req_1, mask_req_0}),
    .sync_out(pin_sync)
  );

  irpu_sync #(.W(8)) u_ad_sync (
    .clk(clk),
    .ce(ce),
    .reset(reset),
    .async_in(ad_in),
    .sync_out(ad_sync)
  );

  // pins that serve as outputs or as the select strobe carry no request
  assign req_lvl[0] = pin_sync[0];
  assign req_lvl[1] = pin_sync[1] & ~slave_en;
  assign req_lvl[2] = pin_sync[2] & ~casc0;
  assign req_lvl[3] = pin_sync[3] & ~casc1 & ~slave_en;
  assign req_lvl[4] = pin_sync[4];

  genvar g;
  generate
    for (g = 0; g < NREQ; g = g + 1) begin : g_chan
      irpu_req_chan u_chan (
        .clk(clk),
        .ce(ce),
        .reset(reset),
        .level(req_lvl[g]),
        .trig_level(trig_reg[g]),
        .masked(mask_reg[g]),
        .clear(req_clr[g]),
        .active(req_act[g]),
        .rise(req_rise[g])
      );
    end
  endgenerate

  // lowest input number wins
  reg [2:0] pick_idx;
  reg pick_any;
  integer i;
  always @* begin
    pick_idx = 3'h0;
    pick_any = 1'b0;
    for (i = NREQ - 1; i >= 0; i = i - 1) begin
      if (req_act[i]) begin
        pick_idx = i[2:0];
        pick_any = 1'b1;
      end
    end
  end

  wire sel_rise = pin_sync[1] & ~sel_prev_reg;

  always @* begin
    state_next = state_reg;
    src_next = src_reg;
    type_next = type_reg;
    req_clr = {NREQ{1'b0}};
    casc_cap = 1'b0;
    slv_cap = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (slave_en) begin
          if (req_act[0]) begin
            src_next = 3'h0;
            state_next = ST_SLV;
          end
        end else if (pick_any) begin
          src_next = pick_idx;
          if ((pick_idx == 3'h0 && casc0) || (pick_idx == 3'h1 && casc1)) begin
            state_next = ST_CASC;
          end else begin
            type_next = VEC_BASE + {5'h00, pick_idx};
            state_next = ST_PRES;
          end
        end
      end
      ST_CASC: begin
        // the peripheral has had ACK_CYC cycles to drive its type
        if (cnt_reg == ACK_LAST) begin
          type_next = ad_sync;
          casc_cap = 1'b1;
          state_next = ST_PRES;
        end
      end
      ST_SLV: begin
        if (sel_rise) begin
          type_next = ad_sync;
          slv_cap = 1'b1;
          state_next = ST_PRES;
        end
      end
      ST_PRES: begin
        if (exec_ack) begin
          req_clr[src_reg] = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      src_reg <= 3'h0;
      cnt_reg <= 8'h00;
      type_reg <= 8'h00;
      exec_req_reg <= 1'b0;
      ack0_reg <= 1'b0;
      pin3_reg <= 1'b0;
      ack0_oe_reg <= 1'b0;
      pin3_oe_reg <= 1'b0;
      sel_prev_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      src_reg <= src_next;
      type_reg <= type_next;
      cnt_reg <= (state_reg == ST_CASC) ? cnt_reg + 8'h01 : 8'h00;
      sel_prev_reg <= pin_sync[1];
      exec_req_reg <= (state_next == ST_PRES);
      ack0_reg <= (state_next == ST_CASC) && (src_next == 3'h0);
      // one flop serves pin 3: locally owned requests in slave mode, type ack 1 otherwise
      pin3_reg <= slave_en ? (req_act[2] | req_act[4]) :
        ((state_next == ST_CASC) && (src_next == 3'h1));
      ack0_oe_reg <= casc0;
      pin3_oe_reg <= casc1 | slave_en;
    end
  end

  assign exec_req = exec_req_reg;
  assign exec_type = type_reg;
  assign type_ack_0_out = ack0_reg;
  assign type_ack_0_oe = ack0_oe_reg;
  assign pin3_out = pin3_reg;
  assign pin3_oe = pin3_oe_reg;

  // register writes; byte lanes honoured
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  wire wr_go = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire [31:0] ctrl_w = {{(32-`IRPU_CTRL_W){1'b0}}, ctrl_reg};
  wire [31:0] cfg_w = {19'h00000, trig_reg, 3'h0, mask_reg};
  wire [31:0] imsk_w = {{(32-`IRPU_IST_W){1'b0}}, imsk_reg};
  wire [31:0] ctrl_m = merge(ctrl_w, wdata_reg, wstrb_reg);
  wire [31:0] cfg_m = merge(cfg_w, wdata_reg, wstrb_reg);
  wire [31:0] imsk_m = merge(imsk_w, wdata_reg, wstrb_reg);
  wire [31:0] ist_clr_m = merge(32'h00000000, wdata_reg, wstrb_reg);
  wire wr_map = (awaddr_reg == `IRPU_OFF_CTRL) || (awaddr_reg == `IRPU_OFF_CFG) ||
    (awaddr_reg == `IRPU_OFF_STATE) || (awaddr_reg == `IRPU_OFF_TYPE) ||
    (awaddr_reg == `IRPU_OFF_IST) || (awaddr_reg == `IRPU_OFF_IMSK);

  wire [`IRPU_IST_W-1:0] ist_set = {casc_cap, slv_cap, req_rise};
  wire [`IRPU_IST_W-1:0] ist_clr = (wr_go && awaddr_reg == `IRPU_OFF_IST) ?
    ist_clr_m[`IRPU_IST_W-1:0] : {`IRPU_IST_W{1'b0}};
  // a new event beats a simultaneous write-one clear
  wire [`IRPU_IST_W-1:0] ist_next = (ist_reg & ~ist_clr) | ist_set;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `IRPU_RESP_OKAY;
      ctrl_reg <= `IRPU_CTRL_RST;
      mask_reg <= `IRPU_MASK_RST;
      trig_reg <= `IRPU_TRIG_RST;
      imsk_reg <= {`IRPU_IST_W{1'b0}};
      ist_reg <= {`IRPU_IST_W{1'b0}};
      irq_reg <= 1'b0;
    end else if (ce) begin
      ist_reg <= ist_next;
      irq_reg <= |(ist_next & imsk_reg);
      if (s_axi_awvalid && !aw_hold_reg && !bvalid_reg) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg && !bvalid_reg) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? `IRPU_RESP_OKAY : `IRPU_RESP_SLVERR;
        if (awaddr_reg == `IRPU_OFF_CTRL) begin
          ctrl_reg <= ctrl_m[`IRPU_CTRL_W-1:0];
        end
        if (awaddr_reg == `IRPU_OFF_CFG) begin
          mask_reg <= cfg_m[`IRPU_CFG_MASK_HI:`IRPU_CFG_MASK_LO];
          trig_reg <= cfg_m[`IRPU_CFG_TRIG_HI:`IRPU_CFG_TRIG_LO];
        end
        if (awaddr_reg == `IRPU_OFF_IMSK) begin
          imsk_reg <= imsk_m[`IRPU_IST_W-1:0];
        end
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read side
  reg [31:0] rd_val;
  reg rd_map;
  always @* begin
    rd_val = 32'h00000000;
    rd_map = 1'b1;
    case (s_axi_araddr)
      `IRPU_OFF_CTRL: rd_val = ctrl_w;
      `IRPU_OFF_CFG: rd_val = cfg_w;
      `IRPU_OFF_STATE: begin
        rd_val[`IRPU_ST_STATE_HI:`IRPU_ST_STATE_LO] = state_reg;
        rd_val[`IRPU_ST_ACT_HI:`IRPU_ST_ACT_LO] = req_act;
        rd_val[`IRPU_ST_LVL_HI:`IRPU_ST_LVL_LO] = pin_sync;
      end
      `IRPU_OFF_TYPE: rd_val = {24'h000000, type_reg};
      `IRPU_OFF_IST: rd_val = {{(32-`IRPU_IST_W){1'b0}}, ist_reg};
      `IRPU_OFF_IMSK: rd_val = imsk_w;
      default: rd_map = 1'b0;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `IRPU_RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (ce) begin
      if (s_axi_arvalid && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_val;
        rresp_reg <= rd_map ? `IRPU_RESP_OKAY : `IRPU_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ready flags are flopped from the next handshake state so no output is combinational
  wire aw_take = s_axi_awvalid & ~aw_hold_reg & ~bvalid_reg;
  wire w_take = s_axi_wvalid & ~w_hold_reg & ~bvalid_reg;
  wire b_done = bvalid_reg & s_axi_bready & ~wr_go;
  wire aw_hold_next = (aw_hold_reg | aw_take) & ~wr_go;
  wire w_hold_next = (w_hold_reg | w_take) & ~wr_go;
  wire bvalid_next = (bvalid_reg | wr_go) & ~b_done;
  wire rvalid_next = (s_axi_arvalid & ~rvalid_reg) | (rvalid_reg & ~s_axi_rready);
  reg awready_reg;
  reg wready_reg;
  reg arready_reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b1;
    end else if (ce) begin
      awready_reg <= ~aw_hold_next & ~bvalid_next;
      wready_reg <= ~w_hold_next & ~bvalid_next;
      arready_reg <= ~rvalid_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign irq = irq_reg;
endmodule

// [verification/irpu_sva.sv]
`timescale 1ns/1ps
module irpu_sva #(
  parameter int ACK_CYC = 4
) (
  input logic clk,
  input logic reset,
  input logic type_ack_0_out,
  input logic type_ack_0_oe,
  input logic pin3_out,
  input logic pin3_oe,
  input logic exec_req,
  input logic [7:0] exec_type,
  input logic exec_ack,
  input logic s_axi_awready,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arready,
  input logic s_axi_rvalid
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ack0_pin_a: assert property (type_ack_0_out |-> type_ack_0_oe)
    else $error("ack 0 high while pin 2 not driven");
  pin3_drive_a: assert property (pin3_out |-> pin3_oe)
    else $error("pin 3 high while not driven");
  ack0_len_a: assert property ($rose(type_ack_0_out) |->
    type_ack_0_out [*4] ##1 !type_ack_0_out)
    else $error("ack 0 width wrong");
  ack0_vec_a: assert property ($fell(type_ack_0_out) |-> exec_req)
    else $error("no vector as ack 0 drops");
  vec_hold_a: assert property (exec_req && !exec_ack |=> exec_req && $stable(exec_type))
    else $error("vector changed before ack");
  vec_drop_a: assert property (exec_req && exec_ack |=> !exec_req)
    else $error("vector kept after ack");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule
bind irpu_top irpu_sva #(.ACK_CYC(ACK_CYC)) u_irpu_sva (.clk, .reset, .type_ack_0_out,
  .type_ack_0_oe, .pin3_out, .pin3_oe, .exec_req, .exec_type, .exec_ack, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid);

// [verification/irpu_periph.sv]
`timescale 1ns/1ps
module irpu_periph (
  input logic clk,
  input logic reset,
  input logic ack0,
  input logic oe0,
  input logic ack1,
  input logic oe1,
  input logic slv,
  input logic slv_go,
  input logic slow,
  input logic [7:0] typ,
  output logic req0,
  output logic sel,
  output logic [7:0] ad
);
  logic [3:0] cnt;
  wire acked = (ack0 && oe0) || (ack1 && oe1 && !slv);
  // master raises request 0 well before the select strobe
  assign req0 = cnt != 4'h0;
  assign sel = cnt >= 4'h4;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 4'h0;
      ad <= 8'h00;
    end else begin
      cnt <= (cnt == 4'h0) ? {3'h0, slv_go} : ((cnt == 4'hB) ? 4'h0 : cnt + 4'h1);
      // the type must be on the bus from the first acknowledged edge
      if (acked) begin
        ad <= typ;
      end else if (cnt >= 4'h2) begin
        ad <= typ;
      end else begin
        // released bus: hold ~typ when slow, else toggle every cycle, so no stale type can pass
        ad <= slow ? ~typ : ~ad;
      end
    end
  end
endmodule

// [verification/interrupt_request_pin_unit_bench.sv]
`timescale 1ns/1ps
`include "irpu_consts.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module interrupt_request_pin_unit_bench;
  logic clk = 0;
  logic reset = 1;
  logic exec_ack = 0;
  logic slv_go = 0;
  logic slow = 0;
  logic slv_mode = 0;
  logic [4:0] pins = 0;
  logic [7:0] typ = 0;
  logic [7:0] s_axi_awaddr = 0;
  logic [7:0] s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire type_ack_0_out, type_ack_0_oe, pin3_out, pin3_oe, exec_req, irq, p_req0, p_sel;
  wire [7:0] exec_type, ad_in;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [7:0] exp_q[$];
  logic [7:0] t;
  integer error_cnt = 0, compares = 0, i, n;
  localparam [7:0] VB = 8'h10;
  irpu_top #(.VEC_BASE(VB), .ACK_CYC(4)) u_irpu_top (.clk, .ce(1'b1), .reset,
    .mask_req_0(pins[0] | p_req0), .mask_req_1(pins[1] | p_sel), .mask_req_2_in(pins[2]),
    .type_ack_0_out, .type_ack_0_oe, .mask_req_3_in(pins[3]), .pin3_out, .pin3_oe,
    .mask_req_4(pins[4]), .ad_in, .exec_req, .exec_type, .exec_ack, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  irpu_periph u_irpu_periph (.clk, .reset, .ack0(type_ack_0_out), .oe0(type_ack_0_oe),
    .ack1(pin3_out), .oe1(pin3_oe), .slv(u_irpu_top.pin3_oe && !pins[3] && slv_mode),
    .slv_go, .slow, .typ, .req0(p_req0), .sel(p_sel), .ad(ad_in));
  initial begin
    forever #50 clk = ~clk;
  end
  task test_done;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    aw = 1;
    w = 1;
    b = 0;
    // sample mid-cycle what the next rising edge sees, then act right after it
    for (n = 0; n < 100 && !b; n++) begin
      @(negedge clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      b = s_axi_bvalid;
      @(posedge clk);
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
      if (b) s_axi_bready <= 0;
    end
    if (!b) begin error_cnt++; test_done; end
  endtask
  task rd(input logic [7:0] a);
    logic ar, r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    ar = 1;
    r = 0;
    for (n = 0; n < 100 && !r; n++) begin
      @(negedge clk);
      ar = ar && !s_axi_arready;
      r = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      s_axi_arvalid <= ar;
      if (r) s_axi_rready <= 0;
    end
    if (!r) begin error_cnt++; test_done; end
  endtask
  // waits for the vector, checks it against the model, then acknowledges it
  task take(input logic drop);
    logic [7:0] e;
    for (n = 0; n < 300 && exec_req !== 1'b1; n++) @(posedge clk);
    if (n >= 300) begin error_cnt++; test_done; end
    e = exp_q.pop_front();
    `CHK("exec_type", e, exec_type)
    if (drop) pins <= 5'h00;
    if (drop) repeat (6) @(posedge clk);
    exec_ack <= 1;
    @(posedge clk);
    exec_ack <= 0;
  endtask
  initial begin
    void'($urandom(32'hF5B4));
    repeat (8) @(posedge clk);
    reset <= 0;
    rd(`IRPU_OFF_CFG);
    `CHK("cfg reset", 32'h0000001F, rv)
    rd(8'h20);
    `CHK("unmapped rresp", `IRPU_RESP_SLVERR, rr)
    wr(`IRPU_OFF_CFG, 32'h0);
    wr(`IRPU_OFF_IMSK, 32'h7F);
    for (i = 0; i < 5; i++) begin
      repeat ($urandom % 4) @(posedge clk);
      pins[i] <= 1;
      exp_q.push_back(VB + i[7:0]);
      repeat (2) @(posedge clk);
      `CHK("sync delay", 1'b0, exec_req)
      take(1);
      rd(`IRPU_OFF_IST);
      `CHK("edge status", 32'h1 << i, rv)
      `CHK("irq set", 1'b1, irq)
      wr(`IRPU_OFF_IST, 32'h1 << i);
      rd(`IRPU_OFF_IST);
      `CHK("irq clear", 1'b0, irq)
    end
    wr(`IRPU_OFF_IMSK, 32'h0);
    wr(`IRPU_OFF_CFG, 32'h10);
    pins[4] <= 1;
    repeat (10) @(posedge clk);
    `CHK("masked request", 1'b0, exec_req)
    `CHK("irq masked", 1'b0, irq)
    pins[4] <= 0;
    // the edge seen while masked stays latched and fires once unmasked
    wr(`IRPU_OFF_CFG, 32'h0);
    exp_q.push_back(VB + 8'h4);
    take(0);
    wr(`IRPU_OFF_CFG, 32'h1000);
    pins[4] <= 1;
    exp_q.push_back(VB + 8'h4);
    exp_q.push_back(VB + 8'h4);
    take(0);
    take(1);
    repeat (6) @(posedge clk);
    `CHK("level released", 1'b0, exec_req)
    for (i = 0; i < 3; i++) begin
      wr(`IRPU_OFF_CTRL, 32'h1 << i);
      t = $urandom;
      typ <= t;
      slow <= i == 0;
      slv_mode <= i == 2;
      exp_q.push_back(t);
      if (i < 2) pins[i] <= 1;
      slv_go <= i == 2;
      @(posedge clk);
      slv_go <= 0;
      take(i < 2);
      `CHK("pin 2 drive", i == 0, type_ack_0_oe)
      `CHK("pin 3 drive", i != 0, pin3_oe)
    end
    pins[2] <= 1;
    for (n = 0; n < 20 && pin3_out !== 1'b1; n++) @(posedge clk);
    `CHK("slave request", 1'b1, pin3_out)
    test_done;
  end
endmodule
